/* verilog/adcsr_pkg.sv */
/*
 * Constants and types for the converter sequencer and serial readout.
 * Assumes a 25 MHz system clock; all times are turned into cycles here.
 */
package adcsr_pkg;
    localparam int CLK_HZ        = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;

    // internal power-on reset pulse after supply is good
    localparam int POR_TIME_NS = 500_000;
    localparam int POR_CYCLES  = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // longest half period of an external oscillator on rate_sel
    localparam int EXT_OSC_HALF_NS   = 390_000;
    localparam int EXT_DETECT_CYCLES = (EXT_OSC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // oscillator runs at notch frequency times this divisor
    localparam int NOTCH_50_HZ = 50;
    localparam int NOTCH_60_HZ = 60;
    localparam int NOTCH_DIV   = 2560;
    localparam logic [7:0] DIV_50_LAST = 8'(CLK_HZ / (NOTCH_50_HZ * NOTCH_DIV) - 1);
    localparam logic [7:0] DIV_60_LAST = 8'(CLK_HZ / (NOTCH_60_HZ * NOTCH_DIV) - 1);

    // oscillator ticks in one conversion
    localparam int CONV_TICKS = 20510;

    // internal shift clock runs at oscillator / 8: four ticks per half period
    localparam logic [1:0] SCK_HALF_LAST = 2'h3;
    localparam logic [5:0] WORD_LAST_BIT = 6'h1F;

    localparam logic EOC_BUSY = 1'h1;
    localparam logic EOC_DONE = 1'h0;
    localparam logic FILLER   = 1'h0;

    typedef enum logic [1:0] {
        ST_CONV   = 2'b00,
        ST_SLEEP  = 2'b01,
        ST_OUTPUT = 2'b10
    } adcsr_state_t;
endpackage

/* verilog/adcsr_top.sv */
/*
 * Conversion sequencer and 3-wire serial readout of a delta-sigma converter.
 * Assumes the filter delivers its 30-bit word on i_conv_word, valid when the
 * conversion ends; i_reset_n is the supply-good level from the analog monitor.
 * Pins select_n, shift clock and rate_sel are asynchronous and are synchronised.
 */
// Notes on behaviour
// [R1] cycle conversion, sleep, data output, repeat
// [R2] select low enables output, wakes converter
// [R3] after conversion sleep while select high
// [R4] select rising during output aborts, reconverts
// [R5] select high puts data pin high-Z
// [R6] conversion/sleep show done flag on data
// [R7] internal mode drives shift clock, else input
// [R8] pull-up on shift clock in internal mode
// [R9] clock mode sampled at power-up, select fall
// [R10] rate_sel high 50Hz, low 60Hz oscillator
// [R11] clock on rate_sel becomes system clock
// [R12] data changes on falling shift clock edges
// [R13] output ends after 32 bits or select high
// [R14] result held unchanged during sleep
// [R15] word is the conversion just completed
// [R16] held in reset while supply low
// [R17] power-on pulse of about 0.5ms
// [R18] power-on clears all, then conversion starts
// [R19] calibration inside conversion, timing unchanged
// [R20] word: done flag, filler, sign, result, sub-LSBs
// [R21] sign and MSB equal mark out of range
// [R22] after 32nd fall data goes high
// [R23] shift clocks ignored while select high
// [R24] low level means external, high internal
// [R25] internal mode: 32 pulses, idle high
module adcsr_top #(
    parameter int POR_LEN    = adcsr_pkg::POR_CYCLES,
    parameter int EXT_DETECT = adcsr_pkg::EXT_DETECT_CYCLES,
    parameter int CONV_LEN   = adcsr_pkg::CONV_TICKS
) (
    input  wire logic        i_sys_clk,            // system clock
    input  wire logic        i_reset_n,            // supply good, async
    input  wire logic        i_select_n,           // select pin
    input  wire logic        i_sck_in,             // shift clock pin level
    output logic             o_sck_out,            // shift clock drive value
    output logic             o_sck_oe_n,           // shift clock drive enable
    output logic             o_sck_pullup_en,      // weak pull-up on shift clock
    output logic             o_serial_result_out,  // serial data value
    output logic             o_serial_result_oe_n, // serial data drive enable
    input  wire logic        i_rate_sel,           // rate pin or external clock
    input  wire logic [29:0] i_conv_word,          // sign, result, sub-LSBs
    output logic             o_conv_start,         // pulse: conversion begins
    output logic             o_sleeping,           // converter in sleep
    output logic             o_ext_clk_mode,       // external shift clock mode
    output logic             o_ext_osc,            // rate_sel carries a clock
    output logic             o_over_range,         // last result above range
    output logic             o_under_range         // last result below range
);

    typedef struct packed {
        adcsr_pkg::adcsr_state_t state;
        logic                    por_busy;
        logic [15:0]             por_cnt;
        logic                    cs_m;
        logic                    cs_s;
        logic                    cs_d;
        logic                    sck_m;
        logic                    sck_s;
        logic                    sck_d;
        logic                    rate_m;
        logic                    rate_s;
        logic                    rate_d;
        logic [15:0]             edge_gap;
        logic                    ext_osc;
        logic [7:0]              div_cnt;
        logic                    tick;
        logic [15:0]             conv_cnt;
        logic [1:0]              half_cnt;
        logic [5:0]              bit_cnt;
        logic [31:0]             shreg;
        logic                    sck_drv;
        logic                    ext_mode;
        logic                    conv_start;
        logic                    over;
        logic                    under;
    } adcsr_regs_t;

    adcsr_regs_t r;
    adcsr_regs_t next_r;
    logic        rate_edge;
    logic        cs_fall;
    logic        sck_fall;
    logic        shift;

    always_comb begin
        next_r = r;
        rate_edge = r.rate_s ^ r.rate_d;
        cs_fall = r.cs_d & ~r.cs_s;
        sck_fall = r.sck_d & ~r.sck_s;
        shift = 1'h0;
        next_r.cs_m = i_select_n;
        next_r.cs_s = r.cs_m;
        next_r.cs_d = r.cs_s;
        next_r.sck_m = i_sck_in;
        next_r.sck_s = r.sck_m;
        next_r.sck_d = r.sck_s;
        next_r.rate_m = i_rate_sel;
        next_r.rate_s = r.rate_m;
        next_r.rate_d = r.rate_s;
        next_r.conv_start = 1'h0;
        next_r.tick = 1'h0;

        // a toggling rate pin is an external oscillator
        // synchroniser settling after reset is not an oscillator edge
        if (rate_edge && !r.por_busy) begin
            next_r.edge_gap = '0;
        end else if (r.edge_gap < 16'(EXT_DETECT)) begin
            next_r.edge_gap = r.edge_gap + 16'h0001;
        end
        next_r.ext_osc = r.edge_gap < 16'(EXT_DETECT);

        if (r.ext_osc) begin
            next_r.tick = r.rate_s & ~r.rate_d; // R11
        end else if (r.div_cnt == '0) begin
            next_r.tick = 1'h1;
            next_r.div_cnt = r.rate_s ? adcsr_pkg::DIV_50_LAST : adcsr_pkg::DIV_60_LAST; // R10
        end else begin
            next_r.div_cnt = r.div_cnt - 8'h01;
        end

        if (r.por_busy) begin
            // the sequencer is held until the pulse ends; synchronisers and divider keep running
            if (r.por_cnt == 16'(POR_LEN - 1)) begin // R17
                next_r.por_busy = 1'h0;
                next_r.ext_mode = ~r.sck_s; // R9 R24
                next_r.state = adcsr_pkg::ST_CONV; // R18
                next_r.conv_start = 1'h1;
            end else begin
                next_r.por_cnt = r.por_cnt + 16'h0001;
            end
        end else begin
            if (cs_fall) begin
                next_r.ext_mode = ~r.sck_s; // R9 R24
            end
            case (r.state)
                adcsr_pkg::ST_CONV: begin
                    // calibration is part of the conversion count // R19
                    if (r.tick) begin
                        if (r.conv_cnt == 16'(CONV_LEN - 1)) begin
                            next_r.state = adcsr_pkg::ST_SLEEP; // R1 R3
                            next_r.conv_cnt = '0;
                            next_r.shreg = {adcsr_pkg::EOC_DONE, adcsr_pkg::FILLER,
                                            i_conv_word}; // R15 R20
                            next_r.over = i_conv_word[29] & i_conv_word[28]; // R21
                            next_r.under = ~i_conv_word[29] & ~i_conv_word[28]; // R21
                        end else begin
                            next_r.conv_cnt = r.conv_cnt + 16'h0001;
                        end
                    end
                end
                adcsr_pkg::ST_SLEEP: begin
                    // shift register untouched while here // R14
                    if (!r.cs_s) begin
                        next_r.state = adcsr_pkg::ST_OUTPUT; // R2
                        next_r.bit_cnt = '0;
                        next_r.half_cnt = '0;
                        next_r.sck_drv = 1'h0;
                    end
                end
                adcsr_pkg::ST_OUTPUT: begin
                    if (r.cs_s) begin
                        next_r.state = adcsr_pkg::ST_CONV; // R4 R13 R23
                        next_r.shreg[31] = adcsr_pkg::EOC_BUSY;
                        next_r.sck_drv = 1'h1;
                        next_r.conv_start = 1'h1;
                    end else begin
                        if (r.ext_mode) begin
                            shift = sck_fall; // R7
                        end else if (r.tick) begin
                            if (r.half_cnt == adcsr_pkg::SCK_HALF_LAST) begin
                                next_r.half_cnt = '0;
                                next_r.sck_drv = ~r.sck_drv; // R7
                                shift = r.sck_drv;
                            end else begin
                                next_r.half_cnt = r.half_cnt + 2'h1;
                            end
                        end
                        if (shift) begin
                            // a one shifts in, becoming the busy flag // R12 R22
                            next_r.shreg = {r.shreg[30:0], adcsr_pkg::EOC_BUSY};
                            next_r.bit_cnt = r.bit_cnt + 6'h01;
                            if (r.bit_cnt == adcsr_pkg::WORD_LAST_BIT) begin
                                next_r.state = adcsr_pkg::ST_CONV; // R13 R1
                                next_r.sck_drv = 1'h1; // R25
                                next_r.conv_start = 1'h1;
                            end
                        end
                    end
                end
                default: begin
                    next_r.state = adcsr_pkg::ST_CONV;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0; // R16 R18
            r.por_busy <= 1'h1;
            r.cs_m <= 1'h1;
            r.cs_s <= 1'h1;
            r.cs_d <= 1'h1;
            r.sck_m <= 1'h1;
            r.sck_s <= 1'h1;
            r.sck_d <= 1'h1;
            r.edge_gap <= 16'hFFFF;
            r.shreg[31] <= adcsr_pkg::EOC_BUSY;
            r.sck_drv <= 1'h1;
        end else begin
            r <= next_r;
        end
    end

    assign o_serial_result_out = r.shreg[31]; // R6
    assign o_serial_result_oe_n = r.cs_s; // R2 R5
    assign o_sck_out = r.sck_drv;
    assign o_sck_oe_n = ~((r.state == adcsr_pkg::ST_OUTPUT) & ~r.ext_mode
                          & ~r.por_busy); // R7
    assign o_sck_pullup_en = ~r.ext_mode; // R8
    assign o_conv_start = r.conv_start;
    assign o_sleeping = (r.state == adcsr_pkg::ST_SLEEP) & ~r.por_busy;
    assign o_ext_clk_mode = r.ext_mode;
    assign o_ext_osc = r.ext_osc;
    assign o_over_range = r.over;
    assign o_under_range = r.under;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    AST_HIZ_IDLE: assert property (r.cs_s |-> o_serial_result_oe_n) // R5
        else $error("data pin driven while select high");
    AST_ABORT: assert property ((r.state == adcsr_pkg::ST_OUTPUT) && r.cs_s && !r.por_busy
        |=> (r.state == adcsr_pkg::ST_CONV) && o_conv_start && o_serial_result_out) // R4
        else $error("select rise did not abort output");
    AST_SLEEP_HOLD: assert property ((r.state == adcsr_pkg::ST_SLEEP)
        && ($past(r.state) == adcsr_pkg::ST_SLEEP) |-> $stable(r.shreg)) // R14
        else $error("result changed during sleep");
    AST_BUSY_FLAG: assert property ((r.state == adcsr_pkg::ST_CONV) && !r.por_busy
        |-> o_serial_result_out) // R6
        else $error("busy flag not shown during conversion");
    AST_LAST_BIT: assert property ((r.state == adcsr_pkg::ST_OUTPUT) && !r.cs_s && shift
        && (r.bit_cnt == adcsr_pkg::WORD_LAST_BIT) |=> (r.state == adcsr_pkg::ST_CONV)
        && o_serial_result_out ##1 (r.state == adcsr_pkg::ST_CONV)) // R22
        else $error("32nd edge did not end output");
    AST_WAKE: assert property ((r.state == adcsr_pkg::ST_SLEEP) && !r.cs_s && !r.por_busy
        |=> (r.state == adcsr_pkg::ST_OUTPUT) && !o_serial_result_oe_n) // R2
        else $error("select low did not wake converter");
    AST_PULLUP: assert property (!o_sck_oe_n |-> o_sck_pullup_en && !o_ext_clk_mode) // R8
        else $error("shift clock driven in external mode");
    AST_ORDER: assert property ((r.state == adcsr_pkg::ST_OUTPUT) && !r.por_busy
        |-> $past(r.state) != adcsr_pkg::ST_CONV) // R1
        else $error("output entered straight from conversion");
    AST_STOP_HIGH: assert property ($fell(r.state == adcsr_pkg::ST_OUTPUT) && !r.ext_mode
        |-> o_sck_out) // R25
        else $error("internal shift clock not idle high");

    // sequencing after power-on and around each conversion
    AST_POR_QUIET: assert property (r.por_busy
        |-> o_sck_oe_n && !o_conv_start && o_serial_result_out) // R16
        else $error("activity during power-on pulse");

    AST_POR_END: assert property ($fell(r.por_busy)
        |-> o_conv_start && (o_ext_clk_mode == !$past(r.sck_s))) // R9 R18
        else $error("power-on end did not latch mode and start");

    AST_START_PULSE: assert property (o_conv_start
        |-> (r.state == adcsr_pkg::ST_CONV) && o_serial_result_out) // R1 R13
        else $error("conversion start outside conversion state");

    AST_WORD_LOAD: assert property ((r.state == adcsr_pkg::ST_CONV) && r.tick
        && (r.conv_cnt == 16'(CONV_LEN - 1)) && !r.por_busy
        |=> r.shreg == {adcsr_pkg::EOC_DONE, adcsr_pkg::FILLER, $past(i_conv_word)}) // R15
        else $error("finished word not loaded");

    AST_RANGE: assert property ($rose(o_sleeping)
        |-> (o_over_range == (r.shreg[29] & r.shreg[28]))
        && (o_under_range == (!r.shreg[29] & !r.shreg[28]))) // R21
        else $error("range flags disagree with word");

    // sleep and wake
    AST_SLEEP_STAY: assert property ((r.state == adcsr_pkg::ST_SLEEP) && r.cs_s
        && !r.por_busy |=> (r.state == adcsr_pkg::ST_SLEEP)) // R3
        else $error("left sleep while select high");

    AST_SLEEP_FLAG: assert property ((r.state == adcsr_pkg::ST_SLEEP) && !r.por_busy
        |-> !o_serial_result_out) // R6
        else $error("done flag not shown in sleep");

    AST_DESEL_HOLD: assert property ((r.state == adcsr_pkg::ST_SLEEP) && r.cs_s
        |=> $stable(r.shreg)) // R23
        else $error("shift register moved while deselected");

    // shifting and clock ownership
    AST_MODE_LATCH: assert property (cs_fall && !r.por_busy
        |=> o_ext_clk_mode == !$past(r.sck_s)) // R9 R24
        else $error("clock mode not latched at select fall");

    AST_SCK_START: assert property ((r.state == adcsr_pkg::ST_SLEEP) && !r.cs_s
        && !r.por_busy |=> !o_sck_out) // R7
        else $error("shift clock not low at output start");

    AST_SHIFT_ONE: assert property ((r.state == adcsr_pkg::ST_OUTPUT) && !r.cs_s && shift
        |=> (r.shreg[31:1] == $past(r.shreg[30:0])) && r.shreg[0]) // R12
        else $error("shift register did not advance by one");

    AST_BIT_LIMIT: assert property ((r.state == adcsr_pkg::ST_OUTPUT)
        |-> r.bit_cnt <= adcsr_pkg::WORD_LAST_BIT) // R13 R25
        else $error("more than a word shifted");

    COV_FULL_READ: cover property ((r.state == adcsr_pkg::ST_OUTPUT) && shift
        && (r.bit_cnt == adcsr_pkg::WORD_LAST_BIT));
    COV_INT_READ: cover property ((r.state == adcsr_pkg::ST_OUTPUT) && !r.ext_mode && shift);
    COV_ABORT: cover property ((r.state == adcsr_pkg::ST_OUTPUT) && r.cs_s);
    COV_EXT_MODE: cover property ((r.state == adcsr_pkg::ST_OUTPUT) && r.ext_mode && shift);
    COV_EXT_OSC: cover property (r.ext_osc && (r.state == adcsr_pkg::ST_SLEEP));

endmodule

/* verification/adcsr_host.sv */
/*
 * Host model: drives select and, when it owns the shift clock, clocks it;
 * captures the data pin on every rising edge of the shift clock pin while select is low.
 * Assumes the bench resolves both pins from the enables of all parties.
 */
module adcsr_host (
    input  wire logic        i_sys_clk,         // system clock
    input  wire logic        i_go,              // pulse: start a read
    input  wire logic [5:0]  i_nbits,           // clocks to give in external mode
    input  wire logic        i_ext,             // host owns the shift clock
    input  wire logic        i_stray,           // toggle clock while deselected
    input  wire logic        i_sdo,             // data pin level
    input  wire logic        i_sck,             // shift clock pin level
    output logic             o_select_n = 1'b1, // select pin
    output logic             o_sck = 1'b0,      // host drive value
    output logic             o_sck_drv_n,       // low = host drives the pin
    output logic [31:0]      o_word,            // captured bits
    output logic [6:0]       o_nrise = 7'h00,   // rising edges while selected
    output logic             o_done = 1'b0      // pulse: read over
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sck_q = 1'b0;

    assign o_sck_drv_n = !i_ext;

    always @(posedge i_sys_clk) begin
        sck_q <= i_sck;
        if (i_go) begin
            o_nrise <= 7'h00;
        end else if (i_sck && !sck_q && !o_select_n) begin
            o_word  <= {o_word[30:0], i_sdo};
            o_nrise <= o_nrise + 7'h01;
        end
    end

    always @(posedge i_sys_clk) begin
        o_done <= 1'b0;
        if (i_go) begin
            // low at the select fall so external mode is latched
            o_sck <= 1'b0;
            repeat (4) @(posedge i_sys_clk);
            o_select_n <= 1'b0;
            repeat (8) @(posedge i_sys_clk);
            repeat (i_ext ? i_nbits : 6'h00) begin
                o_sck <= 1'b1;
                repeat (8) @(posedge i_sys_clk);
                o_sck <= 1'b0;
                repeat (8) @(posedge i_sys_clk);
            end
            for (int k = 0; k < 4000 && !i_ext && o_nrise < 7'h20; k++) @(posedge i_sys_clk);
            repeat (i_ext ? 8 : 100) @(posedge i_sys_clk);
            o_select_n <= 1'b1;
            o_done     <= 1'b1;
        end else if (i_stray && o_select_n) begin
            o_sck <= ~o_sck;
            repeat (3) @(posedge i_sys_clk);
        end
    end
endmodule

/* verification/adcsr_top_tb.sv */
/*
 * Bench for the converter sequencer: resets it, reads words in both clock
 * modes, aborts a read and sends stray clocks while deselected.
 * Assumes the host model adcsr_host and the design package.
 */
module adcsr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        go = 1'b0;
    logic [5:0]  nbits = 6'h00;
    logic        ext = 1'b1;
    logic        stray = 1'b0;
    logic        osc_run = 1'b0;
    logic        rate = 1'b1;
    logic [1:0]  ocnt = 2'h0;
    logic [29:0] cw = 30'h3000_0001;
    logic        sel_n, hsck, hdrv_n, done, sck_oe_n, sck_out, pull, sdo_v, sdo_oe_n;
    logic        cstart, sleeping, ext_mode, ext_osc, over, under;
    logic [31:0] word;
    logic [6:0]  nrise;
    wire         sck_pin;
    wire         sdo_pin;
    int          fails = 0;
    int          n_checks = 0;

    // undriven shift clock: pull-up, always reads high
    assign sck_pin = !sck_oe_n ? sck_out : !hdrv_n ? hsck : 1'b1;
    assign sdo_pin = sdo_oe_n ? 1'bz : sdo_v;

    initial begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        ocnt <= ocnt + 2'h1;
        if (osc_run && ocnt == 2'h3) begin
            rate <= ~rate;
        end
    end

    adcsr_top #(.POR_LEN(20), .EXT_DETECT(50), .CONV_LEN(10)) DUT (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_select_n(sel_n), .i_sck_in(sck_pin),
        .o_sck_out(sck_out), .o_sck_oe_n(sck_oe_n), .o_sck_pullup_en(pull),
        .o_serial_result_out(sdo_v), .o_serial_result_oe_n(sdo_oe_n), .i_rate_sel(rate),
        .i_conv_word(cw), .o_conv_start(cstart), .o_sleeping(sleeping),
        .o_ext_clk_mode(ext_mode), .o_ext_osc(ext_osc), .o_over_range(over),
        .o_under_range(under));

    adcsr_host host (
        .i_sys_clk(clk), .i_go(go), .i_nbits(nbits), .i_ext(ext), .i_stray(stray),
        .i_sdo(sdo_pin), .i_sck(sck_pin), .o_select_n(sel_n), .o_sck(hsck),
        .o_sck_drv_n(hdrv_n), .o_word(word), .o_nrise(nrise), .o_done(done));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wait_sleep;
        for (int k = 0; k < 6000 && sleeping !== 1'b1; k++) @(posedge clk);
        chk(sleeping, 1'b1);
    endtask

    task automatic rd(input logic [5:0] n, input logic e);
        @(posedge clk);
        ext   <= e;
        nbits <= n;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int k = 0; k < 5000 && done !== 1'b1; k++) @(posedge clk);
        chk(done, 1'b1);
    endtask

    // 33 clocks: the extra bit is the level left after the 32nd fall
    task automatic t_word(input logic [29:0] exp, input logic [29:0] nxt);
        wait_sleep();
        chk(over, exp[29] & exp[28]);
        chk(under, !(exp[29] | exp[28]));
        cw <= nxt;
        rd(6'h21, 1'b1);
        chk(word, {1'b0, exp, 1'b1});
        chk(ext_mode, 1'b1);
    endtask

    task automatic t_abort(input logic [29:0] exp, input logic [29:0] nxt);
        wait_sleep();
        cw <= nxt;
        rd(6'h0A, 1'b1);
        chk(word[9:0], {2'b00, exp[29:22]});
        for (int k = 0; k < 8 && cstart !== 1'b1; k++) @(posedge clk);
        chk(cstart, 1'b1);
        cyc(2);
        chk(sdo_pin, 1'bz);
        chk(sck_oe_n, 1'b1);
    endtask

    task automatic t_ignore(input logic [29:0] exp, input logic [29:0] nxt);
        wait_sleep();
        stray <= 1'b1;
        cyc(400);
        stray <= 1'b0;
        chk(sdo_oe_n, 1'b1);
        cyc(20);
        t_word(exp, nxt);
    endtask

    task automatic t_internal(input logic [29:0] exp);
        osc_run <= 1'b1;
        cyc(200);
        chk(ext_osc, 1'b1);
        wait_sleep();
        rd(6'h00, 1'b0);
        chk(word, {2'b00, exp});
        chk(nrise, 7'h20);
        chk(ext_mode, 1'b0);
        chk(pull, 1'b1);
        chk(sck_pin, 1'b1);
        osc_run <= 1'b0;
        rate    <= 1'b1;
        cyc(200);
        chk(ext_osc, 1'b0);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    initial begin
        int n;
        cyc(5);
        chk(sdo_oe_n, 1'b1);
        chk(pull, 1'b1);
        chk(cstart, 1'b0);
        rst_n <= 1'b1;
        for (n = 0; n < 100 && cstart !== 1'b1; n++) @(posedge clk);
        chk(n >= 18 && n <= 28, 1'b1);
        t_word(30'h3000_0001, 30'h0ABC_DEF5);
        t_word(30'h0ABC_DEF5, 30'h1234_5678);
        t_abort(30'h1234_5678, 30'h2A5A_5A5A);
        t_ignore(30'h2A5A_5A5A, 30'h15A5_A5A5);
        t_internal(30'h15A5_A5A5);
        tally_and_finish();
    end

    initial begin
        #3_000_000;
        fails++;
        tally_and_finish();
    end
endmodule
